//--- rtl/rec_top.sv
/*
 * Rail error compensator: setpoint, error conversion with reference slewing,
 * nonlinear gain and a second plus first order IIR, three coefficient banks.
 * Assumes an APB master on pclk, sense codes in mV from an analog sampler,
 * ramp_count, ramp_active and load_current from logic on pclk.
 */
`timescale 1ns/1ps
`include "rec_map.svh"

// Function
// (RL1) error passes nonlinear gain, then second-order IIR, then first-order IIR
// (RL2) the first-order section adds the third zero and third pole
// (RL3) three banks: ramp or tracking, regulation, light load
// (RL4) gain code 0..3 gives gain 1,2,4,8 and 8..1 mV resolution
// (RL5) gain code is stored in each coefficient bank
// (RL6) out-of-range error converts to -32 or +31
// (RL7) saturation slews the reference toward range at 0.156 V/ms
// (RL8) error is reference minus sampled differential voltage
// (RL9) sample instant within the period is programmable
// (RL10) five gain regions bounded by four limit thresholds
// (RL11) limits may be asymmetric, all positive leaves negatives on gain 0
// (RL12) after supply is good a start-up delay precedes normal operation
// (RL13) low reset pin holds the block in reset
// (RL14) setpoint from command, offset, loop scale and maximum
// (RL15) host keeps the resulting reference within the maximum
// (RL16) operation mode picks nominal, margin high or margin low
// (RL17) operation option suppresses voltage faults while margined
// (RL18) sample trigger comes from the rail's first modulator ramp timer
// (RL19) leaving light load restores the regulation bank
// (RL20) slewing stops once the converted error is unsaturated
// (RL21) bank changes only at a sample boundary
module rec_top
    import rec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] sense_positive,
    input wire logic [11:0] sense_negative,
    input wire logic digital_supply,
    input wire logic active_low_reset_pin,
    input wire logic [15:0] ramp_count,
    input wire logic ramp_active,
    input wire logic [11:0] load_current,
    output logic [9:0] ref_dac_code,
    output logic [15:0] duty_cycle,
    output logic duty_valid,
    output logic error_sat,
    output logic margin_fault_suppress,
    output logic running
);
    import rec_pkg::*;

    logic [4:0] ctrl_q;
    logic [9:0] vout_cmd_q;
    logic signed [9:0] cal_off_q;
    logic [8:0] scale_q;
    logic [9:0] vout_max_q;
    logic [9:0] margin_hi_q;
    logic [9:0] margin_lo_q;
    logic [15:0] sample_instant_cmd_q;
    logic [11:0] ll_low_q;
    logic [11:0] ll_high_q;
    logic [31:0] coef_q [0:2][0:6];

    logic [11:0] pos_m_q, pos_s_q, neg_m_q, neg_s_q;
    logic sup_m_q, sup_s_q, rst_m_q, rst_s_q;

    rec_start_t start_q;
    logic [11:0] start_cnt_q;
    logic run_en;

    logic [9:0] base;
    logic signed [11:0] sum;
    logic [20:0] prod;
    logic [9:0] target_d, target_q;
    logic [8:0] slew_cnt_q;

    logic light_q;
    rec_bank_t bank_sel, bank_q;
    logic [4:0] stg_q;
    logic signed [13:0] err_mv, err_sh;
    logic [1:0] gain_code;
    logic signed [5:0] err_code_q;
    logic signed [7:0] lim [0:3];
    logic [5:0] nl_gain;
    logic signed [12:0] nl_prod;
    rec_coef_t nl_q, y2, y1;
    logic sat_lo_q, sat_hi_q;

    logic apb_acc, apb_wr, coef_hit;
    logic [1:0] cbank;
    logic [2:0] cidx;
    logic [31:0] rdata;
    logic rerr;

    // shared two-flop synchronisers for the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pos_m_q, pos_s_q, neg_m_q, neg_s_q, sup_m_q, sup_s_q, rst_m_q, rst_s_q} <= '0;
        end else begin
            {pos_m_q, neg_m_q, sup_m_q, rst_m_q} <= {sense_positive, sense_negative, digital_supply, active_low_reset_pin};
            {pos_s_q, neg_s_q, sup_s_q, rst_s_q} <= {pos_m_q, neg_m_q, sup_m_q, rst_m_q};
        end
    end

    // (RL12) start-up delay sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= st_hold;
            start_cnt_q <= '0;
            running <= 1'b0;
        end else if (!rst_s_q || !sup_s_q) begin
            // (RL13) pin low holds reset
            start_q <= st_hold;
            start_cnt_q <= '0;
            running <= 1'b0;
        end else begin
            unique case (start_q)
                st_hold: start_q <= st_delay;
                st_delay: begin
                    if (start_cnt_q == 12'(`REC_STARTUP_CYC - 1)) begin
                        start_q <= st_run;
                        running <= 1'b1;
                    end else begin
                        start_cnt_q <= start_cnt_q + 12'h001;
                    end
                end
                st_run: running <= 1'b1;
                default: start_q <= st_hold;
            endcase
        end
    end

    assign run_en = running && ctrl_q[`REC_CTRL_EN];

    // (RL16) mode chooses which level regulates
    always_comb begin
        unique case (rec_op_t'(ctrl_q[`REC_CTRL_OP_LSB +: 2]))
            op_margin_high: base = margin_hi_q;
            op_margin_low: base = margin_lo_q;
            default: base = vout_cmd_q;
        endcase
        // (RL14) clamp to max, add offset, scale
        if (base > vout_max_q) begin
            base = vout_max_q;
        end
        sum = $signed({2'b00, base}) + 12'(cal_off_q);
        prod = sum[11] ? 21'h0 : 21'(sum[10:0]) * 21'(scale_q);
        target_d = (prod[20:8] > 13'h3ff) ? 10'h3ff : prod[17:8];
    end

    // (RL17) fault suppress only while margined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            margin_fault_suppress <= 1'b0;
        end else begin
            // codes 1 and 2 are the margin modes
            margin_fault_suppress <= ctrl_q[`REC_CTRL_SUPP] && run_en && (^ctrl_q[`REC_CTRL_OP_LSB +: 2]);
        end
    end

    // reference DAC: follows setpoint changes, slews while saturated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {target_q, ref_dac_code, slew_cnt_q} <= '0;
        end else begin
            target_q <= target_d;
            if (target_d != target_q) begin
                ref_dac_code <= target_d;
                slew_cnt_q <= '0;
            end else if (run_en && (sat_lo_q || sat_hi_q)) begin
                // (RL7) one mV per step interval
                if (slew_cnt_q == 9'(`REC_SLEW_STEP_CYC - 1)) begin
                    slew_cnt_q <= '0;
                    if (sat_lo_q && ref_dac_code != 10'h3ff) begin
                        ref_dac_code <= ref_dac_code + 10'h001;
                    end else if (sat_hi_q && ref_dac_code != 10'h000) begin
                        ref_dac_code <= ref_dac_code - 10'h001;
                    end
                end else begin
                    slew_cnt_q <= slew_cnt_q + 9'h001;
                end
            end else begin
                // (RL20) no slewing once unsaturated
                slew_cnt_q <= '0;
            end
        end
    end

    // (RL19) light-load hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            light_q <= 1'b0;
        end else if (!ctrl_q[`REC_CTRL_LL_EN] || load_current > ll_high_q) begin
            light_q <= 1'b0;
        end else if (load_current < ll_low_q) begin
            light_q <= 1'b1;
        end
    end

    // (RL3) bank by operating mode
    assign bank_sel = ramp_active ? `REC_BANK_RAMP : (light_q ? `REC_BANK_LIGHT : `REC_BANK_REG);

    // (RL18) trigger from first modulator ramp timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_q <= '0;
            bank_q <= `REC_BANK_REG;
        end else begin
            // (RL9) programmable sample instant
            stg_q <= {stg_q[3:0], run_en && ramp_count == sample_instant_cmd_q};
            // (RL21) bank latched only at sample start
            if (run_en && ramp_count == sample_instant_cmd_q) begin
                bank_q <= bank_sel;
            end
        end
    end

    // (RL5) gain code from the active bank
    assign gain_code = coef_q[bank_q][`REC_W_GAIN][1:0];

    always_comb begin
        // (RL8) reference minus differential sample
        err_mv = $signed({4'h0, ref_dac_code}) - ($signed({2'b00, pos_s_q}) - $signed({2'b00, neg_s_q}));
        // (RL4) resolution 8,4,2,1 mV
        err_sh = err_mv >>> (2'd3 - gain_code);
    end

    // (RL6) clamp to -32..31
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {err_code_q, sat_lo_q, sat_hi_q, error_sat} <= '0;
        end else if (!run_en) begin
            {sat_lo_q, sat_hi_q, error_sat} <= '0;
        end else if (stg_q[0]) begin
            sat_lo_q <= err_sh < -14'sd32;
            sat_hi_q <= err_sh > 14'sd31;
            error_sat <= err_sh < -14'sd32 || err_sh > 14'sd31;
            if (err_sh < -14'sd32) begin
                err_code_q <= -6'sd32;
            end else if (err_sh > 14'sd31) begin
                err_code_q <= 6'sd31;
            end else begin
                err_code_q <= err_sh[5:0];
            end
        end
    end

    // (RL10) region gain between four limits
    always_comb begin
        nl_gain = coef_q[bank_q][`REC_W_NLGAIN][29:24];
        // (RL11) lowest limit above the error wins, so limits may be asymmetric
        for (int i = 3; i >= 0; i--) begin
            lim[i] = coef_q[bank_q][`REC_W_LIMITS][8*i +: 8];
            if (8'(err_code_q) < lim[i]) begin
                nl_gain = coef_q[bank_q][`REC_W_NLGAIN][6*i +: 6];
            end
        end
        nl_prod = err_code_q * $signed({1'b0, nl_gain});
    end

    // (RL1) nonlinear stage ahead of the filters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nl_q <= '0;
        end else if (stg_q[1]) begin
            nl_q <= 16'(nl_prod >>> 4);
        end
    end

    // (RL1) second-order section
    rec_iir_section u_iir2 (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!run_en),
        .update(stg_q[2]),
        .x(nl_q),
        .b0(coef_q[bank_q][`REC_W_B0B1][15:0]),
        .b1(coef_q[bank_q][`REC_W_B0B1][31:16]),
        .b2(coef_q[bank_q][`REC_W_B2A1][15:0]),
        .a1(coef_q[bank_q][`REC_W_B2A1][31:16]),
        .a2(coef_q[bank_q][`REC_W_A2C0][15:0]),
        .y(y2)
    );

    // (RL2) first-order section, third zero and pole
    rec_iir_section u_iir1 (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!run_en),
        .update(stg_q[3]),
        .x(y2),
        .b0(coef_q[bank_q][`REC_W_A2C0][31:16]),
        .b1(coef_q[bank_q][`REC_W_C1D1][15:0]),
        .b2(16'sh0000),
        .a1(coef_q[bank_q][`REC_W_C1D1][31:16]),
        .a2(16'sh0000),
        .y(y1)
    );

    // negative duty is meaningless to the modulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {duty_cycle, duty_valid} <= '0;
        end else begin
            // clear in the same edge that drops running
            duty_valid <= stg_q[4] && run_en && rst_s_q && sup_s_q;
            if (!run_en || !rst_s_q || !sup_s_q) begin
                duty_cycle <= '0;
            end else if (stg_q[4]) begin
                duty_cycle <= y1[15] ? 16'h0000 : y1;
            end
        end
    end

    // apb: one wait state, write takes effect at the ready edge
    assign apb_acc = psel && penable && pready;
    assign apb_wr = apb_acc && pwrite && !rerr;
    assign coef_hit = paddr >= `REC_COEF_BASE && paddr <= `REC_COEF_END;
    assign cbank = 2'((paddr - `REC_COEF_BASE) >> 5);
    assign cidx = paddr[4:2];

    always_comb begin
        rdata = 32'h0;
        rerr = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            rerr = 1'b1;
        end else if (coef_hit) begin
            if (cidx < 3'(`REC_COEF_WORDS)) begin
                rdata = coef_q[cbank][cidx];
            end else begin
                rerr = 1'b1;
            end
        end else begin
            unique case (paddr)
                `REC_CTRL_OFS: rdata = {27'h0, ctrl_q};
                `REC_VOUT_CMD_OFS: rdata = {22'h0, vout_cmd_q};
                `REC_CAL_OFS_OFS: rdata = {{22{cal_off_q[9]}}, cal_off_q};
                `REC_SCALE_OFS: rdata = {23'h0, scale_q};
                `REC_VOUT_MAX_OFS: rdata = {22'h0, vout_max_q};
                `REC_MARGIN_HI_OFS: rdata = {22'h0, margin_hi_q};
                `REC_MARGIN_LO_OFS: rdata = {22'h0, margin_lo_q};
                `REC_SAMPLE_OFS: rdata = {16'h0, sample_instant_cmd_q};
                `REC_LIGHT_OFS: rdata = {4'h0, ll_high_q, 4'h0, ll_low_q};
                `REC_STATUS_OFS: rdata = {16'h0, error_sat, light_q, bank_q, running, margin_fault_suppress, ref_dac_code};
                default: rerr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pready, pslverr, prdata} <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && rerr;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rerr ? 32'h0 : rdata;
            end
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `REC_CTRL_RST;
            scale_q <= `REC_SCALE_RST;
            vout_max_q <= `REC_VOUT_MAX_RST;
            {vout_cmd_q, cal_off_q, margin_hi_q, margin_lo_q, sample_instant_cmd_q, ll_low_q, ll_high_q} <= '0;
        end else if (apb_wr && !coef_hit) begin
            unique case (paddr)
                `REC_CTRL_OFS: ctrl_q <= pwdata[4:0];
                `REC_VOUT_CMD_OFS: vout_cmd_q <= pwdata[9:0];
                `REC_CAL_OFS_OFS: cal_off_q <= pwdata[9:0];
                `REC_SCALE_OFS: scale_q <= pwdata[8:0];
                `REC_VOUT_MAX_OFS: vout_max_q <= pwdata[9:0];
                `REC_MARGIN_HI_OFS: margin_hi_q <= pwdata[9:0];
                `REC_MARGIN_LO_OFS: margin_lo_q <= pwdata[9:0];
                `REC_SAMPLE_OFS: sample_instant_cmd_q <= pwdata[15:0];
                `REC_LIGHT_OFS: begin
                    ll_low_q <= pwdata[11:0];
                    ll_high_q <= pwdata[27:16];
                end
                default: ;
            endcase
        end
    end

    // coefficient_load_cmd banks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef_q <= '{default: '0};
        end else if (apb_wr && coef_hit) begin
            coef_q[cbank][cidx] <= pwdata;
        end
    end
endmodule : rec_top

//--- rtl/rec_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the rail error compensator.
 * Assumes a 40 MHz pclk and an APB slave decoding byte addresses paddr[7:0].
 */
`ifndef REC_MAP_SVH
`define REC_MAP_SVH

`define REC_CLK_HZ 40000000
// reference slew while saturated, 0.156 V/ms = 156 mV/ms
`define REC_SLEW_MV_PER_MS 156
`define REC_SLEW_STEP_CYC ((`REC_CLK_HZ / 1000) / `REC_SLEW_MV_PER_MS)
`define REC_STARTUP_US 100
`define REC_STARTUP_CYC ((`REC_CLK_HZ / 1000000) * `REC_STARTUP_US)

`define REC_CTRL_OFS 8'h00
`define REC_VOUT_CMD_OFS 8'h04
`define REC_CAL_OFS_OFS 8'h08
`define REC_SCALE_OFS 8'h0c
`define REC_VOUT_MAX_OFS 8'h10
`define REC_MARGIN_HI_OFS 8'h14
`define REC_MARGIN_LO_OFS 8'h18
`define REC_SAMPLE_OFS 8'h1c
`define REC_LIGHT_OFS 8'h20
`define REC_STATUS_OFS 8'h24
`define REC_COEF_BASE 8'h40
`define REC_COEF_END 8'h9f
`define REC_COEF_WORDS 7

`define REC_CTRL_EN 0
`define REC_CTRL_OP_LSB 1
`define REC_CTRL_SUPP 3
`define REC_CTRL_LL_EN 4
`define REC_CTRL_RST 5'h00
`define REC_SCALE_RST 9'h100
`define REC_VOUT_MAX_RST 10'h3ff

`define REC_W_GAIN 0
`define REC_W_LIMITS 1
`define REC_W_NLGAIN 2
`define REC_W_B0B1 3
`define REC_W_B2A1 4
`define REC_W_A2C0 5
`define REC_W_C1D1 6

`define REC_BANK_RAMP 2'h0
`define REC_BANK_REG 2'h1
`define REC_BANK_LIGHT 2'h2

`endif

//--- rtl/rec_pkg.sv
/*
 * Types shared by the rail error compensator files.
 * Assumes rec_map.svh carries every number.
 */
package rec_pkg;
    typedef enum logic [1:0] {op_nominal, op_margin_high, op_margin_low, op_reserved} rec_op_t;
    typedef enum logic [1:0] {st_hold, st_delay, st_run} rec_start_t;
    typedef logic [1:0] rec_bank_t;
    typedef logic signed [15:0] rec_coef_t;
endpackage : rec_pkg

//--- rtl/rec_iir_section.sv
/*
 * One direct-form IIR section up to second order, Q2.14 coefficients.
 * Assumes update is a one-cycle pulse and coefficients are steady around it.
 */
`timescale 1ns/1ps
module rec_iir_section
    import rec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic update,
    input wire rec_coef_t x,
    input wire rec_coef_t b0,
    input wire rec_coef_t b1,
    input wire rec_coef_t b2,
    input wire rec_coef_t a1,
    input wire rec_coef_t a2,
    output rec_coef_t y
);
    rec_coef_t x1_q;
    rec_coef_t x2_q;
    rec_coef_t y2_q;
    logic signed [34:0] acc;
    logic signed [20:0] sh;

    always_comb begin
        acc = 35'(b0) * 35'(x) + 35'(b1) * 35'(x1_q) + 35'(b2) * 35'(x2_q) - 35'(a1) * 35'(y) - 35'(a2) * 35'(y2_q);
        sh = 21'(acc >>> 14);
    end

    // saturate instead of wrapping so a large step cannot flip the sign
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {x1_q, x2_q, y2_q, y} <= '0;
        end else if (clear) begin
            {x1_q, x2_q, y2_q, y} <= '0;
        end else if (update) begin
            x1_q <= x;
            x2_q <= x1_q;
            y2_q <= y;
            if (sh > 21'sd32767) begin
                y <= 16'sh7fff;
            end else if (sh < -21'sd32768) begin
                y <= -16'sh8000;
            end else begin
                y <= sh[15:0];
            end
        end
    end
endmodule : rec_iir_section

//--- verif/rec_top_checker.sv
/* port assertions for rec_top
   assumes binding to rec_top, one pclk domain */
`timescale 1ns/1ps
module rec_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic digital_supply,
    input wire logic active_low_reset_pin,
    input wire logic [9:0] ref_dac_code,
    input wire logic [15:0] duty_cycle,
    input wire logic duty_valid,
    input wire logic error_sat,
    input wire logic running
);
    logic [12:0] up_q;
    logic [9:0] sat_q;
    // cycles with both pins high, saturating so it never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_q <= 13'h0;
        else if (!active_low_reset_pin || !digital_supply) up_q <= 13'h0;
        else if (up_q != 13'h1fff) up_q <= up_q + 13'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sat_q <= 10'h0;
        else if (error_sat && running && $stable(ref_dac_code)) sat_q <= sat_q + 10'h1;
        else sat_q <= 10'h0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait_state;
        psel && penable && !pready;
    endsequence
    sequence s_pin_low;
        !active_low_reset_pin [*6];
    endsequence
    sequence s_supply_low;
        !digital_supply [*6];
    endsequence
    AST_ONE_WAIT: assert property (s_wait_state |=> pready) else $error("no answer after one wait state");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable) else $error("pready outside access");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_PIN_RESET: assert property (s_pin_low |-> !running && duty_cycle == 16'h0)
        else $error("running while reset pin low");
    AST_SUPPLY_RESET: assert property (s_supply_low |-> !running)
        else $error("running while supply low");
    AST_STARTUP_DELAY: assert property ($rose(running) |-> up_q >= 13'd4000)
        else $error("start-up delay too short");
    AST_IDLE_DUTY: assert property (!running |-> duty_cycle == 16'h0 && !duty_valid)
        else $error("duty output while not running");
    AST_VALID_PULSE: assert property (duty_valid |=> !duty_valid)
        else $error("duty_valid longer than one cycle");
    AST_SLEW_BOUND: assert property (sat_q < 10'd300)
        else $error("reference not slewing while saturated");
endmodule : rec_top_checker

bind rec_top rec_top_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .digital_supply,
    .active_low_reset_pin, .ref_dac_code, .duty_cycle, .duty_valid, .error_sat, .running);

//--- verif/rec_rail_model.sv
/* sensed rail and first modulator ramp timer
   assumes rail_mv is the differential rail voltage in mV */
`timescale 1ns/1ps
module rec_rail_model #(parameter int RAMP_PERIOD = 200) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] rail_mv,
    output logic [11:0] sense_positive,
    output logic [11:0] sense_negative,
    output logic [15:0] ramp_count
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ramp_count <= 16'h0;
        else if (ramp_count == 16'(RAMP_PERIOD - 1)) ramp_count <= 16'h0;
        else ramp_count <= ramp_count + 16'h1;
    end
    // nonzero common level so a swapped pair shows up
    assign sense_negative = 12'h064;
    assign sense_positive = sense_negative + rail_mv;
endmodule : rec_rail_model

//--- verif/rec_top_bench.sv
/* self-checking bench for rec_top
   assumes the rail model gives a 200 cycle ramp, sample instant 50 */
`timescale 1ns/1ps
module rec_top_bench;
    import rec_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, digital_supply, active_low_reset_pin;
    logic ramp_active, duty_valid, error_sat, margin_fault_suppress, running;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] sense_positive, sense_negative, load_current, rail_mv;
    logic [15:0] ramp_count, duty_cycle;
    logic [9:0] ref_dac_code, ref_hold;
    int error_cnt, tests_run, cyc;
    int sp[4] = '{500, 550, 450, 500};
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} rec_row_t;
    typedef struct {logic [7:0] a; logic [31:0] d;} rec_cf_t;
    typedef struct {logic [15:0] c0; logic [11:0] mv; logic [15:0] duty;} rec_duty_t;
    rec_row_t rows[13] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h0c, 0, 32'h100, 0}, '{0, 8'h10, 0, 32'h3ff, 0},
        '{1, 8'h04, 32'h1f4, 0, 0}, '{0, 8'h04, 0, 32'h1f4, 0}, '{1, 8'h14, 32'h226, 0, 0},
        '{1, 8'h18, 32'h1c2, 0, 0}, '{1, 8'h1c, 32'h32, 0, 0}, '{1, 8'h20, 32'h00c80064, 0, 0},
        '{0, 8'h28, 0, 0, 1}, '{0, 8'h02, 0, 0, 1}, '{1, 8'h5c, 32'h3, 0, 1}, '{0, 8'ha0, 0, 0, 1}};
    // bank1: gain code 3, limits 1..4, gains 2.0 1.0 1.0 3.0 1.0, b0 1.0
    rec_cf_t cf[8] = '{'{8'h40, 0}, '{8'h80, 0}, '{8'h60, 32'h3}, '{8'h64, 32'h04030201},
        '{8'h68, 32'h10c10420}, '{8'h6c, 32'h4000}, '{8'h70, 0}, '{8'h78, 0}};
    rec_duty_t dt[2] = '{'{16'hc000, 12'd503, 16'd6}, '{16'h4000, 12'd497, 16'd9}};

    rec_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sense_positive, .sense_negative, .digital_supply, .active_low_reset_pin, .ramp_count, .ramp_active,
        .load_current, .ref_dac_code, .duty_cycle, .duty_valid, .error_sat, .margin_fault_suppress, .running);
    rec_rail_model u_rail (.pclk, .presetn, .rail_mv, .sense_positive, .sense_negative, .ramp_count);

    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk32

    task automatic chk1(input logic g, input logic x);
        tests_run++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk1

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // look between edges so pready and prdata are settled, then release after the ready edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic wait_run;
        int n = 0;
        while (running !== 1'b1 && n < 4100) begin
            @(posedge pclk);
            n++;
        end
        chk1(running, 1'b1);
    endtask : wait_run

    task close_out;
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // run length is bounded well above the three start-ups plus the tests
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ramp_active} = '0;
        {digital_supply, active_low_reset_pin} = 2'b11;
        load_current = 12'd1000;
        rail_mv = 12'd500;
        repeat (4) @(posedge pclk);
        chk32(32'({ref_dac_code, duty_cycle, duty_valid, running}), 0);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk32(rows[i].wr ? 32'h0 : rd, rows[i].x);
            chk1(er, rows[i].e);
        end
        apb(1, 8'h00, 32'h1);
        wait_run();
        for (int op = 0; op < 4; op++) begin
            rail_mv <= 12'(sp[op]);
            apb(1, 8'h00, 32'(9 + op * 2));
            repeat (3) @(posedge pclk);
            chk32(32'(ref_dac_code), 32'(sp[op]));
            chk1(margin_fault_suppress, op == 1 || op == 2);
        end
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h10, 32'd300);
        repeat (3) @(posedge pclk);
        chk32(32'(ref_dac_code), 32'd300);
        apb(1, 8'h10, 32'h3ff);
        apb(1, 8'h0c, 32'h80);
        repeat (3) @(posedge pclk);
        chk32(32'(ref_dac_code), 32'd250);
        apb(1, 8'h0c, 32'h100);
        foreach (cf[i]) apb(1, cf[i].a, cf[i].d);
        foreach (dt[i]) begin
            apb(1, 8'h74, {dt[i].c0, 16'h0});
            rail_mv <= dt[i].mv;
            repeat (600) @(posedge pclk);
            chk32(32'(duty_cycle), 32'(dt[i].duty));
        end
        // 100 mV error: in range at gain 1 in bank 0, saturated at gain 8 in bank 1
        rail_mv <= 12'd400;
        ramp_active <= 1;
        repeat (600) @(posedge pclk);
        apb(0, 8'h24, 0);
        chk32(32'(rd[13:12]), 0);
        chk1(error_sat, 1'b0);
        ramp_active <= 0;
        repeat (600) @(posedge pclk);
        chk1(error_sat, 1'b1);
        chk1(ref_dac_code < 10'd500, 1'b1);
        rail_mv <= 12'(ref_dac_code) - 12'd5;
        repeat (400) @(posedge pclk);
        ref_hold = ref_dac_code;
        repeat (600) @(posedge pclk);
        chk32(32'(ref_dac_code), 32'(ref_hold));
        chk1(error_sat, 1'b0);
        apb(1, 8'h00, 32'h11);
        load_current <= 12'd50;
        repeat (600) @(posedge pclk);
        apb(0, 8'h24, 0);
        chk32(32'(rd[14:12]), 32'h6);
        load_current <= 12'd300;
        repeat (600) @(posedge pclk);
        apb(0, 8'h24, 0);
        chk32(32'(rd[14:12]), 32'h1);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) active_low_reset_pin <= 0;
            else digital_supply <= 0;
            repeat (8) @(posedge pclk);
            chk1(running, 1'b0);
            apb(0, 8'h04, 0);
            chk32(rd, 32'h1f4);
            active_low_reset_pin <= 1;
            digital_supply <= 1;
            wait_run();
        end
        close_out();
    end
endmodule : rec_top_bench
